// File: src/rsw_pkg.sv
// rsw_pkg: shared constants, register map, reset values and state type
// assumes a single 20 MHz system clock and a 16-bit register port
package rsw_pkg;

	localparam int          DATA_W           = 16;
	localparam int          ADDR_W           = 4;

	// register offsets
	localparam logic [3:0]  ADDR_PORT0       = 4'h0;
	localparam logic [3:0]  ADDR_AUX         = 4'h1;
	localparam logic [3:0]  ADDR_WAKE        = 4'h2;
	localparam logic [3:0]  ADDR_FLAGS       = 4'h3;
	localparam logic [3:0]  ADDR_TIMER       = 4'h4;
	localparam logic [3:0]  ADDR_STATE       = 4'h5;

	// field positions
	localparam int          FLAG_STATUS_BIT  = 0;
	localparam int          FLAG_CARRY_BIT   = 1;
	localparam int          TIMER_EN_BIT     = 15;
	localparam int          WAKE_S0_IN_BIT   = 0;
	localparam int          WAKE_S1_IN_BIT   = 2;
	localparam int          WAKE_S2_EN_BIT   = 3;

	// reset values
	localparam logic [10:0] PC_RST           = 11'h000;
	localparam logic        SP_RST           = 1'b0;
	localparam logic [3:0]  GREG0_RST        = 4'h0;
	localparam logic        STATUS_RST       = 1'b0;
	localparam logic        CARRY_RST        = 1'b0;
	localparam logic [9:0]  TIMER_RST        = 10'h000;
	localparam logic [7:0]  PORT0_RST        = 8'hff;
	localparam logic [7:0]  AUX_RST          = 8'h03;
	localparam logic [7:0]  WAKE_RST         = 8'h26;

	// standby operand codes, low three bits
	localparam logic [2:0]  OP_STOP_ALL      = 3'h0;
	localparam logic [2:0]  OP_STOP_ALT      = 3'h3;
	localparam logic [2:0]  OP_STOP_K0       = 3'h6;
	localparam logic [2:0]  OP_HALT          = 3'h5;

	// timing
	localparam int          CLK_HZ           = 20_000_000;
	localparam int          SUPPLY_DIP_US    = 1000;
	localparam int          SUPPLY_DIP_CYC   = (CLK_HZ / 1_000_000) * SUPPLY_DIP_US;
	localparam int          OSC_WAIT_MIN_CYC = 246;
	localparam int          OSC_WAIT_MAX_CYC = 694;

	typedef enum logic [2:0] {
		st_reset,
		st_wait,
		st_run,
		st_pend,
		st_stop,
		st_halt
	} rsw_state_t;

endpackage : rsw_pkg

// File: src/rsw_mon_if.sv
// rsw_mon_if: link between the top and the supply dip filter
// assumes both ends run on the same system clock
`timescale 1ns/1ps
interface rsw_mon_if;
	logic supply_low;
	logic mon_rst;
	modport filt (input supply_low, output mon_rst);
	modport top  (output supply_low, input mon_rst);
endinterface : rsw_mon_if

// File: src/rsw_sync.sv
// rsw_sync: two-flop synchroniser for a bundle of pin levels
// assumes each bit is an independent slow level
`timescale 1ns/1ps
module rsw_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         arst_n_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta;

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			meta <= '0;
			q_o  <= '0;
		end
		else
		begin
			meta <= d_i;
			q_o  <= meta;
		end
	end
endmodule : rsw_sync

// File: src/rsw_supply_filter.sv
// rsw_supply_filter: asserts the monitor reset after a long enough supply dip
// assumes supply_low is already synchronised to clk_i
`timescale 1ns/1ps
module rsw_supply_filter #(
	parameter int DIP_CYC = rsw_pkg::SUPPLY_DIP_CYC
) (
	input  wire logic clk_i,
	input  wire logic arst_n_i,
	rsw_mon_if.filt   mon
);
	import rsw_pkg::*;

	localparam int CW = $clog2(DIP_CYC + 1);

	logic [CW-1:0] low_cnt;
	wire           dip_done = (low_cnt == CW'(DIP_CYC - 1));

	// count dip length, release at once on recovery
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			low_cnt     <= '0;
			mon.mon_rst <= 1'b0;
		end
		else if (!mon.supply_low)
		begin
			low_cnt     <= '0;
			mon.mon_rst <= 1'b0;
		end
		else
		begin
			if (!dip_done)
				low_cnt <= low_cnt + CW'(1);
			if (dip_done)
				mon.mon_rst <= 1'b1;
		end
	end

	property p_mon_release;
		@(posedge clk_i) disable iff (!arst_n_i)
		!mon.supply_low |=> !mon.mon_rst;
	endproperty
	a_mon_release: assert property (p_mon_release) else $error("monitor reset not released");

	property p_mon_dip;
		@(posedge clk_i) disable iff (!arst_n_i)
		$rose(mon.mon_rst) |-> $past(low_cnt) == CW'(DIP_CYC - 1);
	endproperty
	a_mon_dip: assert property (p_mon_dip) else $error("monitor reset before dip time");
endmodule : rsw_supply_filter

// File: src/rsw_top.sv
// rsw_top: reset merge, standby entry and wake, oscillator wait control
// assumes cpu strobes are one-cycle pulses on clk_i; pins are asynchronous
`timescale 1ns/1ps

module rsw_top #(
	parameter int DIP_CYC = rsw_pkg::SUPPLY_DIP_CYC
) (
	input  wire logic                        clk_i,
	input  wire logic                        arst_n_i,
	input  wire logic [rsw_pkg::ADDR_W-1:0]  addr_i,
	input  wire logic [rsw_pkg::DATA_W-1:0]  wdata_i,
	input  wire logic                        wr_i,
	input  wire logic                        rd_i,
	output logic      [rsw_pkg::DATA_W-1:0]  rdata_o,
	input  wire logic                        supply_low_i,
	input  wire logic [3:0]                  key_inputs_i,
	input  wire logic [2:0]                  wake_pins_i,
	input  wire logic                        kio_all_high_i,
	input  wire logic                        kio0_high_i,
	input  wire logic                        halt_exec_i,
	input  wire logic [3:0]                  halt_operand_i,
	input  wire logic                        rotate_left_zero_check_i,
	input  wire logic [3:0]                  acc_i,
	input  wire logic                        sp_overflow_i,
	input  wire logic                        sp_underflow_i,
	output logic                             sys_rst_o,
	output logic                             keep_mem_o,
	output logic                             osc_en_o,
	output logic                             cpu_run_o,
	output logic                             standby_o,
	output logic                             status_flag_o,
	output logic                             carry_flag_o,
	output logic      [9:0]                  timer_o,
	output logic                             timer_out_en_o,
	output logic      [7:0]                  output_port_low_o,
	output logic      [7:0]                  aux_control_o,
	output logic      [7:0]                  wake_source_control_o
);
	import rsw_pkg::*;

	localparam logic [9:0] WAIT_LAST = 10'(OSC_WAIT_MIN_CYC - 1);

	rsw_state_t state;
	rsw_state_t next_state;
	logic [7:0] pins_s;
	logic [9:0] wcnt;
	logic       from_stop;
	logic       stop_s_mode;

	// pin synchronisers and supply dip filter
	rsw_sync #(
		.W (8)
	) u_sync (
		.clk_i    (clk_i),
		.arst_n_i (arst_n_i),
		.d_i      ({supply_low_i, wake_pins_i, key_inputs_i}),
		.q_o      (pins_s)
	);

	rsw_mon_if u_mon_if ();
	assign u_mon_if.supply_low = pins_s[7];

	rsw_supply_filter #(
		.DIP_CYC (DIP_CYC)
	) u_filter (
		.clk_i    (clk_i),
		.arst_n_i (arst_n_i),
		.mon      (u_mon_if)
	);

	wire       mon_rst = u_mon_if.mon_rst;
	wire [3:0] keys_s  = pins_s[3:0];
	wire [2:0] spins_s = pins_s[6:4];

	// operand decode and preconditions
	wire [2:0] op_low     = halt_operand_i[2:0];
	wire       op_s       = halt_operand_i[3];
	wire       op_is_halt = (op_low == OP_HALT);
	wire       op_is_stop = (op_low == OP_STOP_ALL) || (op_low == OP_STOP_ALT)
		|| (op_low == OP_STOP_K0);
	wire       stop_pre   = (op_low == OP_STOP_K0) ? kio0_high_i : kio_all_high_i;
	wire [2:0] s_enable   = {wake_source_control_o[WAKE_S2_EN_BIT],
		wake_source_control_o[WAKE_S1_IN_BIT], wake_source_control_o[WAKE_S0_IN_BIT]};
	wire       s_cfg      = |s_enable;
	wire       pre_ok     = op_is_halt || (op_is_stop && stop_pre && (!op_s || s_cfg));

	// release conditions
	wire       key_rel    = |keys_s;
	wire       s_rel      = |(spins_s & s_enable);
	wire       timer_zero = (timer_o == 10'h000);
	wire       timer_busy = !timer_zero || timer_out_en_o;
	wire       stop_rel   = key_rel || (stop_s_mode && s_rel);
	wire       rel_now    = op_is_halt ? timer_zero : (key_rel || (op_s && s_rel));

	// reset sources
	wire       halt_illegal = halt_exec_i && !pre_ok;
	wire       zero_rot_rst = rotate_left_zero_check_i && (acc_i == 4'h0);
	wire       sp_rst       = sp_overflow_i || sp_underflow_i;
	wire       int_req      = halt_illegal || zero_rot_rst || sp_rst || mon_rst;
	wire       other_rst    = halt_illegal || zero_rot_rst || sp_rst;
	wire       in_standby   = (state == st_stop) || (state == st_halt) || (state == st_pend)
		|| ((state == st_wait) && from_stop);

	// standby entry and release
	wire       halt_take  = halt_exec_i && pre_ok && (state == st_run);
	wire       enter_ok   = halt_take && !status_flag_o && !rel_now;
	wire       wait_done  = (state == st_wait) && (wcnt == WAIT_LAST);
	wire       std_rel    = (wait_done && from_stop && stop_rel)
		|| ((state == st_halt) && timer_zero);

	// bus decode
	wire       wr_flags   = wr_i && (addr_i == ADDR_FLAGS);
	wire       wr_timer   = wr_i && (addr_i == ADDR_TIMER);
	wire       flag_set   = std_rel || (halt_take && rel_now)
		|| (wr_flags && wdata_i[FLAG_STATUS_BIT]);
	wire       flag_clr   = (halt_take && status_flag_o && !rel_now)
		|| (wr_flags && !wdata_i[FLAG_STATUS_BIT]);
	wire [2:0] state_code = state;
	wire [DATA_W-1:0] rd_mux =
		(addr_i == ADDR_PORT0) ? DATA_W'(output_port_low_o) :
		(addr_i == ADDR_AUX)   ? DATA_W'(aux_control_o) :
		(addr_i == ADDR_WAKE)  ? DATA_W'(wake_source_control_o) :
		(addr_i == ADDR_FLAGS) ? DATA_W'({carry_flag_o, status_flag_o}) :
		(addr_i == ADDR_TIMER) ? {timer_out_en_o, 5'h00, timer_o} :
		(addr_i == ADDR_STATE) ? DATA_W'({keep_mem_o, from_stop, state_code}) :
		'0;

	// sequencing state machine
	always_comb
	begin
		next_state = state;
		unique case (state)
			st_reset:
				next_state = st_wait;
			st_run:
				if (enter_ok)
					next_state = op_is_halt ? st_halt : (timer_busy ? st_pend : st_stop);
			st_pend:
				if (!timer_busy)
					next_state = st_stop;
			st_stop:
				if (stop_rel)
					next_state = st_wait;
			st_wait:
				if (wcnt == WAIT_LAST)
					next_state = (from_stop && !stop_rel) ? st_stop : st_run;
			st_halt:
				if (timer_zero)
					next_state = st_run;
		endcase
		if (int_req)
			next_state = st_reset;
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			state          <= st_reset;
			sys_rst_o      <= 1'b1;
			osc_en_o       <= 1'b0;
			cpu_run_o      <= 1'b0;
			standby_o      <= 1'b0;
		end
		else
		begin
			state          <= next_state;
			sys_rst_o      <= int_req;
			osc_en_o       <= (next_state != st_reset) && (next_state != st_stop);
			cpu_run_o      <= (next_state == st_run);
			standby_o      <= (next_state == st_stop) || (next_state == st_halt)
				|| (next_state == st_pend);
		end
	end

	// oscillation wait counter and wake bookkeeping
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			wcnt        <= 10'h000;
			from_stop   <= 1'b0;
			stop_s_mode <= 1'b0;
		end
		else
		begin
			wcnt        <= (state == st_wait) ? wcnt + 10'h001 : 10'h000;
			if (state == st_reset)
				from_stop <= 1'b0;
			else if ((state == st_stop) && stop_rel)
				from_stop <= 1'b1;
			if (halt_take)
				stop_s_mode <= op_s;
		end
	end

	// memory keep indication on a fresh reset
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			keep_mem_o <= 1'b0;
		else if (int_req && !sys_rst_o)
			keep_mem_o <= mon_rst && in_standby && !other_rst;
	end

	// status and carry flags; a set wins over a clear
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			status_flag_o <= STATUS_RST;
			carry_flag_o  <= CARRY_RST;
		end
		else if (sys_rst_o)
		begin
			status_flag_o <= STATUS_RST;
			carry_flag_o  <= CARRY_RST;
		end
		else
		begin
			if (flag_set)
				status_flag_o <= 1'b1;
			else if (flag_clr)
				status_flag_o <= 1'b0;
			if (wr_flags)
				carry_flag_o <= wdata_i[FLAG_CARRY_BIT];
		end
	end

	// timer down counter, halted in stop
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			timer_o        <= TIMER_RST;
			timer_out_en_o <= 1'b0;
		end
		else if (sys_rst_o)
		begin
			timer_o        <= TIMER_RST;
			timer_out_en_o <= 1'b0;
		end
		else if (wr_timer)
		begin
			timer_o        <= wdata_i[9:0];
			timer_out_en_o <= wdata_i[TIMER_EN_BIT];
		end
		else if (state != st_stop)
		begin
			if (!timer_zero)
				timer_o <= timer_o - 10'h001;
			else
				timer_out_en_o <= 1'b0;
		end
	end

	// port and control registers
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			output_port_low_o     <= PORT0_RST;
			aux_control_o         <= AUX_RST;
			wake_source_control_o <= WAKE_RST;
		end
		else if (sys_rst_o)
		begin
			output_port_low_o     <= PORT0_RST;
			aux_control_o         <= AUX_RST;
			wake_source_control_o <= WAKE_RST;
		end
		else if (wr_i)
		begin
			if (addr_i == ADDR_PORT0)
				output_port_low_o <= wdata_i[7:0];
			if (addr_i == ADDR_AUX)
				aux_control_o <= wdata_i[7:0];
			if (addr_i == ADDR_WAKE)
				wake_source_control_o <= wdata_i[7:0];
		end
	end

	// read data, valid in the cycle after the strobe only
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			rdata_o <= '0;
		else
			rdata_o <= rd_i ? rd_mux : '0;
	end

	property p_stop_wake;
		@(posedge clk_i) disable iff (!arst_n_i)
		(state == st_stop) && stop_rel && !int_req |=> (state == st_wait);
	endproperty
	a_stop_wake: assert property (p_stop_wake) else $error("stop did not enter wait");
	property p_wait_back;
		@(posedge clk_i) disable iff (!arst_n_i)
		wait_done && from_stop && !stop_rel && !int_req |=> (state == st_stop) && !osc_en_o;
	endproperty
	a_wait_back: assert property (p_wait_back) else $error("wait did not fall back");
	property p_halt_bad;
		@(posedge clk_i) disable iff (!arst_n_i)
		halt_exec_i && !pre_ok |=> sys_rst_o && (state == st_reset);
	endproperty
	a_halt_bad: assert property (p_halt_bad) else $error("illegal standby not reset");
	property p_rot_zero;
		@(posedge clk_i) disable iff (!arst_n_i)
		rotate_left_zero_check_i && (acc_i == 4'h0) |=> sys_rst_o && (state == st_reset);
	endproperty
	a_rot_zero: assert property (p_rot_zero) else $error("zero rotate not reset");
	property p_sp_err;
		@(posedge clk_i) disable iff (!arst_n_i)
		(sp_overflow_i || sp_underflow_i) |=> sys_rst_o && !cpu_run_o;
	endproperty
	a_sp_err: assert property (p_sp_err) else $error("stack error not reset");
	property p_mon_hold;
		@(posedge clk_i) disable iff (!arst_n_i)
		mon_rst |=> sys_rst_o;
	endproperty
	a_mon_hold: assert property (p_mon_hold) else $error("reset not held on low supply");
	property p_rst_vals;
		@(posedge clk_i) disable iff (!arst_n_i)
		sys_rst_o |=> (output_port_low_o == PORT0_RST) && (aux_control_o == AUX_RST)
			&& (wake_source_control_o == WAKE_RST) && (timer_o == TIMER_RST)
			&& !status_flag_o && !carry_flag_o;
	endproperty
	a_rst_vals: assert property (p_rst_vals) else $error("reset values not loaded");
	property p_osc_off;
		@(posedge clk_i) disable iff (!arst_n_i)
		sys_rst_o || (state == st_stop) |-> !osc_en_o;
	endproperty
	a_osc_off: assert property (p_osc_off) else $error("oscillator running");
	property p_run_after_wait;
		@(posedge clk_i) disable iff (!arst_n_i)
		$rose(cpu_run_o) |-> ($past(wcnt) == WAIT_LAST) || ($past(state) == st_halt);
	endproperty
	a_run_after_wait: assert property (p_run_after_wait) else $error("run before wait");
	property p_halt_flag;
		@(posedge clk_i) disable iff (!arst_n_i)
		(state == st_halt) && timer_zero && !int_req |=> status_flag_o && cpu_run_o;
	endproperty
	a_halt_flag: assert property (p_halt_flag) else $error("flag not set on release");
	property p_pend_hold;
		@(posedge clk_i) disable iff (!arst_n_i)
		(state == st_pend) && timer_busy && !int_req |=> (state == st_pend) && osc_en_o;
	endproperty
	a_pend_hold: assert property (p_pend_hold) else $error("stop entered with timer busy");
endmodule : rsw_top

// File: verif/rsw_partner.sv
// rsw_partner: battery supply and key matrix model driven by the bench
// assumes pull-downs on the keys, so an idle key reads low
`timescale 1ns/1ps
module rsw_partner (
	input  wire logic  clk_i,
	output logic       supply_low_o,
	output logic [3:0] key_inputs_o
);
	initial
	begin
		supply_low_o = 1'b0;
		key_inputs_o = 4'h0;
	end
	// one key held high for n cycles
	task automatic press(input int n);
		@(posedge clk_i);
		key_inputs_o <= 4'h1;
		repeat (n) @(posedge clk_i);
		key_inputs_o <= 4'h0;
	endtask : press
	// supply below threshold for n cycles
	task automatic dip(input int n);
		@(posedge clk_i);
		supply_low_o <= 1'b1;
		repeat (n) @(posedge clk_i);
		supply_low_o <= 1'b0;
	endtask : dip
endmodule : rsw_partner

// File: verif/test_reset_standby_wake_control.sv
// test_reset_standby_wake_control: self-checking bench for rsw_top
// assumes the partner model drives supply and keys; dip filter shortened
`timescale 1ns/1ps
module test_reset_standby_wake_control;
	import rsw_pkg::*;
	localparam int DIP = 20;
	logic        clk_i, arst_n_i, wr_i, rd_i, kio_all_high, kio0_high, halt, rot, spo, spu;
	logic [3:0]  addr, op, acc, keys;
	logic [15:0] wdata, rdata;
	logic        supply_low, sys_rst, keep_mem, osc_en, run, standby, status;
	logic [9:0]  timer;
	logic        tmr_en;
	logic        carry;
	logic [2:0]  spins;
	logic [7:0]  port0, aux_reg, wake_reg;
	int          fails, checks_done, cyc, n;

	rsw_partner i_partner (.clk_i(clk_i), .supply_low_o(supply_low), .key_inputs_o(keys));
	rsw_top #(.DIP_CYC(DIP)) i_dut (
		.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr), .wdata_i(wdata),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .supply_low_i(supply_low),
		.key_inputs_i(keys), .wake_pins_i(spins), .kio_all_high_i(kio_all_high),
		.kio0_high_i(kio0_high), .halt_exec_i(halt), .halt_operand_i(op),
		.rotate_left_zero_check_i(rot),
		.acc_i(acc), .sp_overflow_i(spo), .sp_underflow_i(spu), .sys_rst_o(sys_rst),
		.keep_mem_o(keep_mem), .osc_en_o(osc_en), .cpu_run_o(run), .standby_o(standby),
		.status_flag_o(status), .carry_flag_o(carry), .timer_o(timer),
		.timer_out_en_o(tmr_en), .output_port_low_o(port0), .aux_control_o(aux_reg),
		.wake_source_control_o(wake_reg)
	);

	initial
	begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : wrap_up

	always @(posedge clk_i)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			fails++;
			wrap_up();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			fails++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic chk1(input logic got, input logic exp);
		chk({15'h0, got}, {15'h0, exp});
	endtask : chk1

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_i);
		wr_i  <= 1'b1;
		addr  <= a;
		wdata <= d;
		@(posedge clk_i);
		wr_i  <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [15:0] exp);
		@(posedge clk_i);
		rd_i <= 1'b1;
		addr <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
		@(negedge clk_i);
		chk(rdata, exp);
		@(negedge clk_i);
		chk(rdata, 16'h0000);
	endtask : rd

	// one instruction strobe; returns just after the edge that answers it
	task automatic cpu(input int kind, input logic [3:0] v);
		@(posedge clk_i);
		halt <= (kind == 0);
		rot  <= (kind == 1);
		spo  <= (kind == 2);
		spu  <= (kind == 3);
		op   <= v;
		acc  <= v;
		#1 chk1(sys_rst, 1'b0);
		@(posedge clk_i);
		{halt, rot, spo, spu} <= 4'h0;
		#1;
	endtask : cpu

	task automatic wait_run(output int c);
		c = 0;
		while (run !== 1'b1 && c < 1000)
		begin
			@(posedge clk_i);
			#1;
			c++;
		end
		#1 chk1(run, 1'b1);
	endtask : wait_run

	task automatic wake_and_clear();
		fork
			i_partner.press(400);
		join_none
		wait_run(n);
		chk1(status, 1'b1);
		repeat (200) @(posedge clk_i);
		wr(ADDR_FLAGS, 16'h0000);
	endtask : wake_and_clear

	task automatic t_reset();
		repeat (3) @(posedge clk_i);
		chk1(sys_rst, 1'b1);
		chk1(osc_en, 1'b0);
		@(negedge clk_i);
		arst_n_i = 1'b1;
		wait_run(n);
		chk1(n >= OSC_WAIT_MIN_CYC && n <= OSC_WAIT_MAX_CYC, 1'b1);
		rd(ADDR_PORT0, 16'h00ff);
		rd(ADDR_AUX, 16'h0003);
		rd(ADDR_WAKE, 16'h0026);
		rd(ADDR_FLAGS, 16'h0000);
		rd(ADDR_TIMER, 16'h0000);
		rd(4'hf, 16'h0000);
		rd(ADDR_STATE, 16'h0002);
		chk({port0, aux_reg}, 16'hff03);
		chk({8'h00, wake_reg}, 16'h0026);
		chk1(carry, 1'b0);
		wr(ADDR_PORT0, 16'h005a);
		wr(ADDR_AUX, 16'h00a5);
		wr(ADDR_FLAGS, 16'h0002);
		#1 chk({port0, aux_reg}, 16'h5aa5);
		chk1(carry, 1'b1);
		rd(ADDR_FLAGS, 16'h0002);
		$display("reset test done");
	endtask : t_reset

	task automatic t_sources();
		logic [3:0] bad [4];
		bad = '{4'h1, 4'h2, 4'h4, 4'h7};
		cpu(1, 4'h3);
		chk1(sys_rst, 1'b0);
		cpu(1, 4'h0);
		chk1(sys_rst, 1'b1);
		wait_run(n);
		chk({port0, aux_reg}, 16'hff03);
		chk1(carry, 1'b0);
		for (int k = 2; k < 4; k++)
		begin
			cpu(k, 4'h0);
			chk1(sys_rst, 1'b1);
			wait_run(n);
		end
		foreach (bad[k])
		begin
			cpu(0, bad[k]);
			chk1(sys_rst, 1'b1);
			wait_run(n);
		end
		cpu(0, {1'b0, OP_STOP_K0});
		chk1(sys_rst, 1'b1);
		wait_run(n);
		kio_all_high <= 1'b0;
		cpu(0, {1'b0, OP_STOP_ALL});
		chk1(sys_rst, 1'b1);
		wait_run(n);
		$display("reset source test done");
	endtask : t_sources

	task automatic t_stop();
		kio_all_high <= 1'b1;
		cpu(0, {1'b0, OP_STOP_ALL});
		chk1(standby, 1'b1);
		chk1(osc_en, 1'b0);
		fork
			i_partner.press(50);
		join_none
		repeat (12) @(posedge clk_i);
		#1 chk1(osc_en, 1'b1);
		repeat (400) @(posedge clk_i);
		#1 chk1(standby, 1'b1);
		chk1(osc_en, 1'b0);
		wake_and_clear();
		#1 chk1(status, 1'b0);
		$display("stop test done");
	endtask : t_stop

	task automatic t_pend();
		wr(ADDR_TIMER, 16'h8010);
		cpu(0, {1'b0, OP_STOP_ALT});
		chk1(osc_en, 1'b1);
		n = 0;
		while (osc_en !== 1'b0 && n < 100)
		begin
			@(posedge clk_i);
			#1;
			n++;
		end
		#1 chk1(osc_en, 1'b0);
		chk({6'h0, timer}, 16'h0000);
		chk1(tmr_en, 1'b0);
		wake_and_clear();
		$display("stop pending test done");
	endtask : t_pend

	task automatic t_halt();
		wr(ADDR_TIMER, 16'h0020);
		cpu(0, {1'b0, OP_HALT});
		chk1(standby, 1'b1);
		chk1(osc_en, 1'b1);
		wait_run(n);
		chk1(status, 1'b1);
		chk({6'h0, timer}, 16'h0000);
		wr(ADDR_FLAGS, 16'h0000);
		$display("halt test done");
	endtask : t_halt

	task automatic t_swake();
		cpu(0, {1'b1, OP_STOP_ALL});
		chk1(standby, 1'b1);
		fork
		begin
			@(posedge clk_i);
			spins <= 3'h2;
			repeat (400) @(posedge clk_i);
			spins <= 3'h0;
		end
		join_none
		wait_run(n);
		chk1(status, 1'b1);
		repeat (200) @(posedge clk_i);
		wr(ADDR_FLAGS, 16'h0000);
		$display("wake pin test done");
	endtask : t_swake

	task automatic t_supply();
		kio0_high <= 1'b1;
		cpu(0, {1'b0, OP_STOP_K0});
		chk1(standby, 1'b1);
		fork
			i_partner.dip(DIP / 2);
		join_none
		repeat (DIP + 10) @(posedge clk_i);
		#1 chk1(sys_rst, 1'b0);
		fork
			i_partner.dip(3 * DIP);
		join_none
		repeat (DIP - 2) @(posedge clk_i);
		#1 chk1(sys_rst, 1'b0);
		repeat (10) @(posedge clk_i);
		#1 chk1(sys_rst, 1'b1);
		repeat (DIP) @(posedge clk_i);
		#1 chk1(sys_rst, 1'b1);
		wait_run(n);
		chk1(keep_mem, 1'b1);
		cpu(1, 4'h0);
		wait_run(n);
		chk1(keep_mem, 1'b0);
		$display("supply test done");
	endtask : t_supply

	initial
	begin
		arst_n_i     = 1'b0;
		{wr_i, rd_i, halt, rot, spo, spu} = 6'h0;
		kio_all_high = 1'b1;
		kio0_high    = 1'b0;
		spins        = 3'h0;
		addr         = 4'h0;
		wdata        = 16'h0000;
		op           = 4'h0;
		acc          = 4'h0;
		fails        = 0;
		checks_done  = 0;
		cyc          = 0;
		t_reset();
		t_sources();
		t_stop();
		t_pend();
		t_halt();
		t_swake();
		t_supply();
		wrap_up();
	end
endmodule : test_reset_standby_wake_control
